/* icd_regs.svh */
`ifndef ICD_REGS_SVH
`define ICD_REGS_SVH
// register byte offsets, one aligned word each
`define ICD_MAIN_KEY_OFF 12'h000
`define ICD_AUX_KEY_OFF 12'h004
`define ICD_SYS_STAT_OFF 12'h008
`define ICD_HAND_CTL_OFF 12'h00C
`define ICD_IMPULSE_OFF 12'h010
`define ICD_OPTLINK_OFF 12'h014
// channel width in bits
`define ICD_CHAN_W 15
// key code field, bits 1..5 as printed, low five bits here
`define ICD_KEY_LSB 0
`define ICD_KEY_W 5
// printed bit n sits at index n-1
`define ICD_AUX_MARK_BIT 5
`define ICD_AUX_REJECT_BIT 6
`define ICD_SYS_ULLAGE_BIT 0
`define ICD_SYS_LIFTOFF_BIT 4
`define ICD_SYS_OCODER_FAIL_BIT 6
`define ICD_SYS_PLAT_ON_BIT 8
`define ICD_SYS_GUIDE_SEL_BIT 9
`define ICD_SYS_CAGE_BIT 10
`define ICD_SYS_CODER_FAIL_BIT 11
`define ICD_SYS_PLAT_FAIL_BIT 12
`define ICD_SYS_DELAY_REQ_BIT 13
`define ICD_SYS_TEMP_OK_BIT 14
`define ICD_IMP_LANDER_BIT 10
`define ICD_IMP_CONTINUE_BIT 13
`define ICD_OPT_RANGE_Q_BIT 1
`define ICD_OPT_ZERO_BIT 3
`define ICD_OPT_COMP_BIT 4
`define ICD_OPT_BLOCK_UP_BIT 9
// reset value of every channel
`define ICD_CHAN_RST 15'h0000
// turn-on delay requested by the platform, seconds
`define ICD_PLAT_DELAY_S 90
`endif

/* icd_pkg.sv */
package icd_pkg;
  typedef logic [14:0] icd_chan_t;
  // apb request
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
  } icd_apb_req_t;
  // discrete inputs from the far side
  typedef struct packed {
    logic main_key_strobe;
    logic [4:0] main_key_code;
    logic aux_key_strobe;
    logic [4:0] aux_key_code;
    logic mark;
    logic mark_reject;
    logic ullage;
    logic [2:0] sep_thrust;
    logic liftoff;
    logic optics_coder_fail;
    logic platform_on;
    logic guidance_sel;
    logic cage_on;
    logic coder_fail;
    logic platform_fail;
    logic delay_req;
    logic temp_ok;
    logic [5:0] rotation;
    logic [5:0] translation;
    logic [2:0] selectors;
    logic [5:0] min_impulse;
    logic lander_attached;
    logic continue_key;
    logic range_quality;
    logic optics_zero;
    logic optics_comp;
    logic block_uplink;
  } icd_disc_t;
endpackage

/* icd_sync.sv */
`timescale 1ns/1ns
// two-flop synchroniser for a bus of discretes
module icd_sync
  import icd_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic [W-1:0] d, // raw pin levels
  output logic [W-1:0] q // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } icd_sync_st_t;
  icd_sync_st_t st_reg;
  icd_sync_st_t st_next;

  // first stage feeds only the second
  always_comb
  begin
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign q = st_reg.s2;
endmodule

/* icd_input_channels.sv */
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "icd_regs.svh"
// Behaviour
// - main keyboard code in low five bits, except continue key; rest unused
// - auxiliary keyboard code in low five bits, same encoding as main
// - auxiliary bits 6 and 7 show sighting and discard buttons
// - status bit 1 shows ullage present from launcher unit
// - status bit 5 shows liftoff; bits 6 and 8 spare
// - status bits 2 to 4 carry switch states, ignored by logic
// - status bit 7 shows optics angle coder fail
// - status bit 9 shows inertial platform powered on
// - status bit 10 shows guidance selector at computer control
// - status bit 11 shows platform cage switch on
// - status bits 12 and 13 show coder and platform fail
// - status bit 14 requests 90 second platform turn-on delay
// - status bit 15 shows platform temperature within limits
// - hand controller bits 1 to 6 carry rotation commands
// - hand controller bits 7 to 12 carry translation commands
// - hand controller bits 13 to 15 show selector positions
// - impulse bits 1 to 6 carry minimum impulse inputs; bits 7 to 10, 12, 13 and 15 spare
// - impulse bit 11 shows lander vehicle attached
// - impulse bit 14 shows continue key pressed
// - link bit 2 shows ranging data quality; listed bits spare
// - link bits 4 and 5 show optics zero and computer modes
// - link bit 10 blocks uplink acceptance
// - each channel at most 15 independent bits
module icd_input_channels
  import icd_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data, unused
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire icd_disc_t disc, // raw discretes from pins
  output logic uplink_blocked // uplink acceptance blocked
);
  localparam int DW = $bits(icd_disc_t);

  ////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    icd_chan_t main_key;
    icd_chan_t aux_key;
    icd_chan_t sys_stat;
    icd_chan_t hand_ctl;
    icd_chan_t impulse;
    icd_chan_t optlink;
    logic [31:0] rdata;
    logic rerr;
  } icd_state_t;

  icd_state_t st_reg;
  icd_state_t st_next;
  icd_disc_t ds;
  logic [DW-1:0] ds_raw;
  logic access;
  logic write_hit;
  icd_chan_t rd_sel;
  logic rd_ok;

  ////////////////////////////////////////////////////////////////////
  // every pin passes two flops before use
  icd_sync #(
    .W(DW)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(disc),
    .q(ds_raw)
  );
  assign ds = icd_disc_t'(ds_raw);

  ////////////////////////////////////////////////////////////////////
  // apb decode; setup phase only samples, access completes at once
  assign access = psel && penable;
  assign write_hit = access && pwrite;

  // read mux by address; unmapped words answer with slverr
  always_comb
  begin
    rd_sel = `ICD_CHAN_RST;
    rd_ok = 1'b1;
    case (paddr)
      `ICD_MAIN_KEY_OFF: rd_sel = st_reg.main_key;
      `ICD_AUX_KEY_OFF: rd_sel = st_reg.aux_key;
      `ICD_SYS_STAT_OFF: rd_sel = st_reg.sys_stat;
      `ICD_HAND_CTL_OFF: rd_sel = st_reg.hand_ctl;
      `ICD_IMPULSE_OFF: rd_sel = st_reg.impulse;
      `ICD_OPTLINK_OFF: rd_sel = st_reg.optlink;
      default: rd_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // channel images, refreshed every cycle from synchronised pins
  always_comb
  begin
    st_next = st_reg;
    // unused positions default to zero
    st_next.main_key = `ICD_CHAN_RST;
    st_next.aux_key = `ICD_CHAN_RST;
    st_next.sys_stat = `ICD_CHAN_RST;
    st_next.hand_ctl = `ICD_CHAN_RST;
    st_next.impulse = `ICD_CHAN_RST;
    st_next.optlink = `ICD_CHAN_RST;
    // key code held while the keyboard strobes it
    if (ds.main_key_strobe)
      st_next.main_key[`ICD_KEY_LSB +: `ICD_KEY_W] = ds.main_key_code;
    if (ds.aux_key_strobe)
      st_next.aux_key[`ICD_KEY_LSB +: `ICD_KEY_W] = ds.aux_key_code;
    st_next.aux_key[`ICD_AUX_MARK_BIT] = ds.mark;
    st_next.aux_key[`ICD_AUX_REJECT_BIT] = ds.mark_reject;
    st_next.sys_stat[`ICD_SYS_ULLAGE_BIT] = ds.ullage;
    // switch states reach software only; nothing here reacts
    st_next.sys_stat[3:1] = ds.sep_thrust;
    st_next.sys_stat[`ICD_SYS_LIFTOFF_BIT] = ds.liftoff;
    st_next.sys_stat[`ICD_SYS_OCODER_FAIL_BIT] = ds.optics_coder_fail;
    st_next.sys_stat[`ICD_SYS_PLAT_ON_BIT] = ds.platform_on;
    st_next.sys_stat[`ICD_SYS_GUIDE_SEL_BIT] = ds.guidance_sel;
    st_next.sys_stat[`ICD_SYS_CAGE_BIT] = ds.cage_on;
    st_next.sys_stat[`ICD_SYS_CODER_FAIL_BIT] = ds.coder_fail;
    st_next.sys_stat[`ICD_SYS_PLAT_FAIL_BIT] = ds.platform_fail;
    // software times the delay; only the request is passed
    st_next.sys_stat[`ICD_SYS_DELAY_REQ_BIT] = ds.delay_req;
    st_next.sys_stat[`ICD_SYS_TEMP_OK_BIT] = ds.temp_ok;
    st_next.hand_ctl[5:0] = ds.rotation;
    st_next.hand_ctl[11:6] = ds.translation;
    st_next.hand_ctl[14:12] = ds.selectors;
    st_next.impulse[5:0] = ds.min_impulse;
    st_next.impulse[`ICD_IMP_LANDER_BIT] = ds.lander_attached;
    st_next.impulse[`ICD_IMP_CONTINUE_BIT] = ds.continue_key;
    st_next.optlink[`ICD_OPT_RANGE_Q_BIT] = ds.range_quality;
    st_next.optlink[`ICD_OPT_ZERO_BIT] = ds.optics_zero;
    st_next.optlink[`ICD_OPT_COMP_BIT] = ds.optics_comp;
    st_next.optlink[`ICD_OPT_BLOCK_UP_BIT] = ds.block_uplink;
    // read data captured in setup so it stands during access
    if (psel && !penable)
    begin
      st_next.rdata = {17'h00000, rd_sel};
      st_next.rerr = !rd_ok || pwrite;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////
  // outputs; all channels read-only, so writes get slverr
  assign prdata = st_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = access && st_reg.rerr;
  assign uplink_blocked = st_reg.optlink[`ICD_OPT_BLOCK_UP_BIT];
endmodule

/* icd_input_channels_chk.sv */
`timescale 1ns/1ns
// read data is judged the cycle after setup, where it first stands
module icd_input_channels_chk
  import icd_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pslverr, // error
  input wire icd_disc_t disc, // pin levels
  input wire logic uplink_blocked // uplink gate
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  property p_hi; prdata[31:15] == 17'h00000; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_key; psel && !penable && paddr == 12'h000
    |=> prdata[14:5] == 10'h000; endproperty
  a_key: assert property (p_key) else $error("main key spare set");
  property p_aux; psel && !penable && paddr == 12'h004
    |=> prdata[14:7] == 8'h00; endproperty
  a_aux: assert property (p_aux) else $error("aux spare set");
  property p_sys; psel && !penable && paddr == 12'h008
    |=> !prdata[7] && !prdata[5]; endproperty
  a_sys: assert property (p_sys) else $error("status spare set");
  property p_imp; psel && !penable && paddr == 12'h010
    |=> !prdata[14] && prdata[12:11] == 2'h0 && prdata[9:6] == 4'h0;
  endproperty
  a_imp: assert property (p_imp) else $error("impulse spare set");
  property p_opt; psel && !penable && paddr == 12'h014
    |=> prdata[14:10] == 5'h00 && prdata[8:5] == 4'h0 && !prdata[2]
    && !prdata[0]; endproperty
  a_opt: assert property (p_opt) else $error("link spare set");
  property p_unm; psel && !penable && paddr > 12'h014 ##1 penable
    |-> pslverr && prdata == 32'h00000000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  // three flops of latency, so four steady samples are enough
  property p_upl; $stable(disc.block_uplink)[*4]
    |-> uplink_blocked == disc.block_uplink; endproperty
  a_upl: assert property (p_upl) else $error("uplink gate wrong");
endmodule
bind icd_input_channels icd_input_channels_chk u_chk (.pclk, .presetn,
  .psel, .penable, .paddr, .prdata, .pslverr, .disc, .uplink_blocked);

/* icd_far.sv */
`timescale 1ns/1ns
// keyboards, switches and detectors; levels held by the bench word
module icd_far
  import icd_pkg::*;
(
  input wire logic [53:0] pins, // switch and key levels
  output icd_disc_t disc // discretes to the device
);
  // plain levels, no bounce modelled
  assign disc = icd_disc_t'(pins);
endmodule

/* icd_input_channels_tb.sv */
`timescale 1ns/1ns
module icd_input_channels_tb
  import icd_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, upl, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd, rd, rn2;
  logic hang;
  logic [53:0] pins;
  icd_disc_t disc;
  int n_fail, tests_run;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // expected channel word from pin levels
  function automatic icd_chan_t exp_ch(input int i, input icd_disc_t d);
    case (i)
      0: exp_ch = {10'h000,
        d.main_key_strobe ? d.main_key_code : 5'h00};
      1: exp_ch = {8'h00, d.mark_reject, d.mark,
        d.aux_key_strobe ? d.aux_key_code : 5'h00};
      2: exp_ch = {d.temp_ok, d.delay_req,
        d.platform_fail, d.coder_fail,
        d.cage_on, d.guidance_sel, d.platform_on, 1'b0,
        d.optics_coder_fail, 1'b0, d.liftoff,
        d.sep_thrust, d.ullage};
      3: exp_ch = {d.selectors, d.translation, d.rotation};
      4: exp_ch = {1'b0, d.continue_key, 2'h0,
        d.lander_attached, 4'h0, d.min_impulse};
      default: exp_ch = {5'h00, d.block_uplink, 4'h0,
        d.optics_comp, d.optics_zero, 1'b0,
        d.range_quality, 1'b0};
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, s);
    tests_run++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one apb transfer; an idle edge follows so psel is never driven twice
  task automatic apb(input logic wr, input logic [11:0] a,
    output logic [31:0] d, output logic e);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    // a hang ends the scenario loops and falls through to the report
    if (pready !== 1'b1)
    begin
      n_fail++;
      hang = 1'b1;
    end
    chk("pready", 32'h1, {31'h0, pready});
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  icd_far u_far (.pins(pins), .disc(disc));
  icd_input_channels dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .disc(disc),
    .uplink_blocked(upl));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // all-ones and all-zeros pins first, then random levels
  initial
  begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pins = '0;
    n_fail = 0;
    tests_run = 0;
    rnd = 32'h050B;
    hang = 1'b0;
    repeat (10) @(posedge pclk);
    chk("reset_rdata", 32'h0, prdata);
    chk("reset_err", 32'h0, {31'h0, pslverr});
    presetn <= 1'b1;
    for (int t = 0; t < 40 && !hang; t++)
    begin
      rnd = lfsr(rnd);
      rn2 = lfsr(rnd);
      pwdata <= rnd;
      pins <= (t == 0) ? '1 : (t == 1) ? '0 : {rn2[21:0], rnd};
      apb(1'b1, 12'(4 * (t % 6)), rd, er);
      chk("write_err", 32'h1, {31'h0, er});
      repeat (2) @(posedge pclk);
      for (int i = 0; i < 6 && !hang; i++)
      begin
        apb(1'b0, 12'(4 * i), rd, er);
        chk("channel", {17'h0, exp_ch(i, disc)}, rd);
        chk("read_err", 32'h0, {31'h0, er});
      end
      chk("uplink", {31'h0, disc.block_uplink}, {31'h0, upl});
      apb(1'b0, 12'h018 + 12'(4 * (t % 3)), rd, er);
      chk("unmapped_err", 32'h1, {31'h0, er});
      chk("unmapped_data", 32'h0, rd);
    end
    wrap_up();
  end
endmodule
